// File: cprs_pkg.sv
// Shared constants, command codes and carrier types for the
// programmer register set of a small 8-bit processor core.
// Assumes one 10 MHz clock and a synchronous active-high reset.
//
// Notes on behaviour
// - Eight-bit accumulator holds operands and results
// - Eight-bit index register addresses indexed accesses
// - Reset loads fetch pointer from vector pair
// - Fetch pointer advances after each consumed byte
// - Fetch pointer is thirteen bits wide
// - Sixteen-bit view shows upper three bits zero
// - Flags register top three bits read one
// - Push writes at stack pointer, then decrements
// - Pull reads the most recently pushed byte
// - Reset and reinit set stack pointer fixed
// - Decimal add is binary add then adjust
// - Adjust on nibble carry or invalid digit
// - Half-carry flag records low nibble carry
// - Data bus is eight bits wide
// - Address bus carries thirteen address lines
// - Core registers occupy no memory address
// - One shared memory-mapped space for everything
// - Each memory access takes one bus cycle
// - Processor clock is input clock halved

package cprs_pkg;

	////////////////////////////////////////////////////////////////////
	// Widths and timing
	localparam int ADDR_W = 13;        // Address lines
	localparam int DATA_W = 8;         // Data lines
	localparam int CLK_PERIOD_NS = 100;  // Input clock period
	localparam int PROC_DIV = 2;         // Processor clock divider
	localparam int PROC_PERIOD_NS = CLK_PERIOD_NS * PROC_DIV;
	localparam logic CE_PHASE = 1'h1;    // Divider phase giving enable
	localparam logic DIV_RESET = 1'h0;   // Divider value after reset

	////////////////////////////////////////////////////////////////////
	// Fixed locations and reset values
	localparam logic [12:0] VEC_HI_ADDR = 13'h1ffe; // Vector high byte
	localparam logic [12:0] VEC_LO_ADDR = 13'h1fff; // Vector low byte
	localparam logic [7:0]  SP_RESET    = 8'hff;    // Stack pointer start
	localparam logic [4:0]  STACK_PAGE  = 5'h00;    // Stack page bits
	localparam logic [4:0]  INDEX_PAGE  = 5'h00;    // Indexed page bits
	localparam logic [12:0] PC_RESET    = 13'h0000; // Before vector load
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam logic [7:0]  IDX_RESET   = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Flags register layout
	localparam logic [2:0] CC_ONES  = 3'h7;   // Unused top bits
	localparam logic [4:0] CC_RESET = 5'h08;  // Interrupt mask set
	localparam int CC_C = 0;   // Carry
	localparam int CC_Z = 1;   // Zero
	localparam int CC_N = 2;   // Negative
	localparam int CC_I = 3;   // Interrupt mask
	localparam int CC_H = 4;   // Half carry
	localparam logic [2:0] PC_UPPER_ZERO = 3'h0;

	////////////////////////////////////////////////////////////////////
	// Decimal adjust constants
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
	localparam logic [3:0] BCD_FIX       = 4'h6;

	////////////////////////////////////////////////////////////////////
	// Command codes; codes c..f are ignored
	typedef enum logic [3:0] {
		OP_NOP   = 4'h0,
		OP_LDA   = 4'h1,  // Accumulator from command data
		OP_LDX   = 4'h2,  // Index from command data
		OP_LDCC  = 4'h3,  // Low five flag bits from data
		OP_ADD   = 4'h4,  // Binary add data to accumulator
		OP_ADDD  = 4'h5,  // Decimal add data to accumulator
		OP_RSP   = 4'h6,  // stack_pointer_reinit_instr
		OP_FETCH = 4'h7,  // Read byte at next_fetch_pointer
		OP_PUSHA = 4'h8,  // Push accumulator
		OP_PULLA = 4'h9,  // Pull into accumulator
		OP_LDAX  = 4'ha,  // Accumulator from memory at index
		OP_STAX  = 4'hb   // Accumulator to memory at index
	} cprs_op_t;

	// Request from the sequencing logic
	typedef struct packed {
		logic       valid;
		cprs_op_t   op;
		logic [7:0] data;
	} cprs_cmd_t;

	// One memory bus access
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} cprs_bus_t;

	localparam cprs_bus_t BUS_IDLE = '{13'h0000, 8'h00, 1'b0, 1'b0};

endpackage : cprs_pkg

// File: cprs_bcd_add.sv
// Binary adder with optional decimal adjust for packed BCD bytes.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns

module cprs_bcd_add (
	input  wire logic [7:0] i_a,       // Accumulator operand
	input  wire logic [7:0] i_b,       // Second operand
	input  wire logic       i_decimal, // Apply decimal adjust
	output logic      [7:0] o_sum,     // Result
	output logic            o_carry,   // Carry out
	output logic            o_half     // Low nibble carry
);

	////////////////////////////////////////////////////////////////////
	// Plain binary sums
	logic [4:0] lo_sum;   // Low nibble sum with carry
	logic [8:0] bin_sum;  // Full sum with carry
	logic       lo_fix;   // Low digit needs correction
	logic       hi_fix;   // High digit needs correction
	logic [7:0] adj;      // Correction to add

	assign lo_sum  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
	assign bin_sum = {1'b0, i_a} + {1'b0, i_b};
	assign o_half  = lo_sum[4];

	////////////////////////////////////////////////////////////////////
	// Correct on a digit carry or an A..F digit
	assign lo_fix = lo_sum[4] | (bin_sum[3:0] > cprs_pkg::BCD_DIGIT_MAX);
	assign hi_fix = bin_sum[8] | (bin_sum[7:0] > cprs_pkg::BCD_BYTE_MAX);
	assign adj = {hi_fix ? cprs_pkg::BCD_FIX : 4'h0,
		lo_fix ? cprs_pkg::BCD_FIX : 4'h0};

	// Decimal carry is the high correction itself
	assign o_sum   = i_decimal ? bin_sum[7:0] + adj : bin_sum[7:0];
	assign o_carry = i_decimal ? hi_fix : bin_sum[8];

endmodule : cprs_bcd_add

// File: cprs_stack.sv
// Stack pointer with pre-increment pull and post-decrement push.
// Assumes the caller never asks to increment and decrement at once.
`timescale 1ns/1ns

module cprs_stack (
	input  wire logic        i_clk,       // Core clock
	input  wire logic        i_rst,       // Synchronous reset
	input  wire logic        i_reinit,    // Reinit instruction
	input  wire logic        i_pre_inc,   // Pull starts
	input  wire logic        i_post_dec,  // Push finished
	output logic       [7:0] o_sp,        // Stack pointer
	output logic      [12:0] o_push_addr, // Where a push writes
	output logic      [12:0] o_pull_addr  // Where a pull reads
);

	logic [7:0] sp;  // Pointer within the stack page

	////////////////////////////////////////////////////////////////////
	// Pointer register; reinit beats any movement
	always_ff @(posedge i_clk)
	begin
		if (i_rst || i_reinit)
			sp <= cprs_pkg::SP_RESET;
		else if (i_pre_inc)
			sp <= sp + 8'h01;
		else if (i_post_dec)
			sp <= sp - 8'h01;
	end

	// Pull reads the slot above, where the last push landed
	assign o_sp        = sp;
	assign o_push_addr = {cprs_pkg::STACK_PAGE, sp};
	assign o_pull_addr = {cprs_pkg::STACK_PAGE, sp + 8'h01};

endmodule : cprs_stack

// File: cprs_core.sv
// Programmer register set of the core: accumulator, index,
// fetch pointer, flags and stack, with the memory bus sequencer.
// Assumes a memory that answers a read within one processor cycle
// on i_rdata, and a sequencer that issues one command at a time.
`timescale 1ns/1ns

module cprs_core (
	input  wire logic                i_clk,         // 10 MHz clock
	input  wire logic                i_rst,         // Sync reset
	input  wire cprs_pkg::cprs_cmd_t i_cmd,         // Command
	output logic                     o_cmd_ready,   // Command taken
	input  wire logic          [7:0] i_rdata,       // Memory read data
	output cprs_pkg::cprs_bus_t      o_bus,         // Memory access
	output logic               [7:0] o_acc,         // Accumulator
	output logic               [7:0] o_idx,         // Index register
	output logic              [15:0] o_pc16,        // Fetch pointer
	output logic               [7:0] o_ccr,         // Flags
	output logic               [7:0] o_sp,          // Stack pointer
	output logic                     o_fetch_valid, // Fetched byte
	output logic               [7:0] o_fetch_data   // Fetched value
);

	////////////////////////////////////////////////////////////////////
	// Sequencer states; all eight codes are used
	typedef enum logic [2:0] {
		ST_VEC_HI  = 3'b000,  // Reading vector high byte
		ST_VEC_LO  = 3'b001,  // Reading vector low byte
		ST_READY   = 3'b010,  // Waiting for a command
		ST_FETCH   = 3'b011,  // Instruction byte read
		ST_PUSH    = 3'b100,  // Stack write
		ST_PULL    = 3'b101,  // Stack read
		ST_LOADX   = 3'b110,  // Indexed read
		ST_STOREX  = 3'b111   // Indexed write
	} cprs_state_t;

	cprs_state_t         state;       // Current state
	cprs_state_t         next_state;  // Following state
	cprs_state_t         op_state;    // State a command enters
	cprs_pkg::cprs_bus_t bus;         // Registered bus access
	cprs_pkg::cprs_bus_t next_bus;    // Following bus access
	cprs_pkg::cprs_bus_t op_bus;      // Access a command starts
	logic                div;         // Clock divider
	logic                ce;          // Processor clock enable
	logic          [7:0] acc;         // Accumulator
	logic          [7:0] idx;         // Index register
	logic         [12:0] pc;          // next_fetch_pointer
	logic          [4:0] cc;          // Stored flag bits
	logic          [7:0] sum;         // Adder result
	logic                sum_c;       // Adder carry
	logic                sum_h;       // Adder half carry
	logic         [12:0] push_addr;   // Stack write address
	logic         [12:0] pull_addr;   // Stack read address

	////////////////////////////////////////////////////////////////////
	// Decoded strobes
	logic take;       // Command accepted this edge
	logic take_add;   // Either add
	logic take_push;
	logic take_pull;
	logic take_rsp;
	logic bus_done;   // Bus access ends this edge
	logic vec_hi_done;
	logic vec_lo_done;
	logic load_done;  // Read into accumulator ends

	// Read request to a given address
	function automatic cprs_pkg::cprs_bus_t bus_rd(
		input logic [12:0] addr);
		bus_rd = '{addr, 8'h00, 1'b1, 1'b0};
	endfunction : bus_rd

	// Write request of a byte to a given address
	function automatic cprs_pkg::cprs_bus_t bus_wr(
		input logic [12:0] addr,
		input logic [7:0]  data);
		bus_wr = '{addr, data, 1'b0, 1'b1};
	endfunction : bus_wr

	// True when a command carries the given code
	function automatic logic is_op(
		input cprs_pkg::cprs_cmd_t cmd,
		input cprs_pkg::cprs_op_t  op);
		is_op = cmd.valid && (cmd.op == op);
	endfunction : is_op

	////////////////////////////////////////////////////////////////////
	// Processor clock enable: one pulse every second edge
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			div <= cprs_pkg::DIV_RESET;
		else
			div <= ~div;
	end

	// First pulse falls on the second cycle after reset
	assign ce = (div == cprs_pkg::CE_PHASE);

	////////////////////////////////////////////////////////////////////
	// Command acceptance happens only on a processor cycle
	assign o_cmd_ready = (state == ST_READY) && ce;
	assign take        = o_cmd_ready && i_cmd.valid;
	assign take_add    = o_cmd_ready && (is_op(i_cmd, cprs_pkg::OP_ADD)
		|| is_op(i_cmd, cprs_pkg::OP_ADDD));
	assign take_push   = o_cmd_ready && is_op(i_cmd, cprs_pkg::OP_PUSHA);
	assign take_pull   = o_cmd_ready && is_op(i_cmd, cprs_pkg::OP_PULLA);
	assign take_rsp    = o_cmd_ready && is_op(i_cmd, cprs_pkg::OP_RSP);

	// Every access state lasts exactly one processor cycle
	assign bus_done    = ce && (state != ST_READY)
		&& (state != ST_VEC_HI) && (state != ST_VEC_LO);
	assign vec_hi_done = ce && (state == ST_VEC_HI);
	assign vec_lo_done = ce && (state == ST_VEC_LO);
	assign load_done   = ce && ((state == ST_PULL) || (state == ST_LOADX));

	////////////////////////////////////////////////////////////////////
	// Command to state and bus access; program, data and I/O alike
	assign op_state =
		(i_cmd.op == cprs_pkg::OP_FETCH) ? ST_FETCH :
		(i_cmd.op == cprs_pkg::OP_PUSHA) ? ST_PUSH :
		(i_cmd.op == cprs_pkg::OP_PULLA) ? ST_PULL :
		(i_cmd.op == cprs_pkg::OP_LDAX)  ? ST_LOADX :
		(i_cmd.op == cprs_pkg::OP_STAX)  ? ST_STOREX : ST_READY;
	assign op_bus =
		(i_cmd.op == cprs_pkg::OP_FETCH) ? bus_rd(pc) :
		(i_cmd.op == cprs_pkg::OP_PUSHA) ? bus_wr(push_addr, acc) :
		(i_cmd.op == cprs_pkg::OP_PULLA) ? bus_rd(pull_addr) :
		(i_cmd.op == cprs_pkg::OP_LDAX)  ?
			bus_rd({cprs_pkg::INDEX_PAGE, idx}) :
		(i_cmd.op == cprs_pkg::OP_STAX)  ?
			bus_wr({cprs_pkg::INDEX_PAGE, idx}, acc) :
		cprs_pkg::BUS_IDLE;

	////////////////////////////////////////////////////////////////////
	// Next state and access
	always_comb
	begin
		next_state = state;
		next_bus   = bus;
		unique case (state)
			ST_VEC_HI:
				if (ce)
				begin
					next_state = ST_VEC_LO;
					next_bus   = bus_rd(cprs_pkg::VEC_LO_ADDR);
				end
			ST_VEC_LO:
				if (ce)
				begin
					next_state = ST_READY;
					next_bus   = cprs_pkg::BUS_IDLE;
				end
			ST_READY:
				if (take)
				begin
					next_state = op_state;
					next_bus   = op_bus;
				end
			ST_FETCH, ST_PUSH, ST_PULL, ST_LOADX, ST_STOREX:
				if (ce)
				begin
					// Bus released so back-to-back accesses show a gap
					next_state = ST_READY;
					next_bus   = cprs_pkg::BUS_IDLE;
				end
		endcase
	end

	// State and bus registers; reset starts the vector read
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state <= ST_VEC_HI;
			bus   <= bus_rd(cprs_pkg::VEC_HI_ADDR);
		end
		else
		begin
			state <= next_state;
			bus   <= next_bus;
		end
	end

	// Registers are never decoded from the address bus
	assign o_bus = bus;

	////////////////////////////////////////////////////////////////////
	// Adder and stack
	cprs_bcd_add u_add (
		.i_a       (acc),
		.i_b       (i_cmd.data),
		.i_decimal (i_cmd.op == cprs_pkg::OP_ADDD),
		.o_sum     (sum),
		.o_carry   (sum_c),
		.o_half    (sum_h)
	);

	cprs_stack u_stack (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_reinit    (take_rsp),
		.i_pre_inc   (take_pull),
		.i_post_dec  (bus_done && (state == ST_PUSH)),
		.o_sp        (o_sp),
		.o_push_addr (push_addr),
		.o_pull_addr (pull_addr)
	);

	////////////////////////////////////////////////////////////////////
	// Accumulator
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			acc <= cprs_pkg::ACC_RESET;
		else if (take && is_op(i_cmd, cprs_pkg::OP_LDA))
			acc <= i_cmd.data;
		else if (take_add)
			acc <= sum;
		else if (load_done)
			acc <= i_rdata;
	end

	// Index register
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			idx <= cprs_pkg::IDX_RESET;
		else if (take && is_op(i_cmd, cprs_pkg::OP_LDX))
			idx <= i_cmd.data;
	end

	////////////////////////////////////////////////////////////////////
	// Flags; add updates H N Z C, pull and indexed load update N Z
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cc <= cprs_pkg::CC_RESET;
		else if (take && is_op(i_cmd, cprs_pkg::OP_LDCC))
			cc <= i_cmd.data[4:0];
		else if (take_add)
		begin
			cc[cprs_pkg::CC_H] <= sum_h;
			cc[cprs_pkg::CC_N] <= sum[7];
			cc[cprs_pkg::CC_Z] <= (sum == 8'h00);
			cc[cprs_pkg::CC_C] <= sum_c;
		end
		else if (load_done)
		begin
			cc[cprs_pkg::CC_N] <= i_rdata[7];
			cc[cprs_pkg::CC_Z] <= (i_rdata == 8'h00);
		end
	end

	// Top bits are not stored at all, so they cannot drift
	assign o_ccr = {cprs_pkg::CC_ONES, cc};

	////////////////////////////////////////////////////////////////////
	// Fetch pointer: vector bytes, then one step per fetched byte
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			pc <= cprs_pkg::PC_RESET;
		else if (vec_hi_done)
			pc[12:8] <= i_rdata[4:0];
		else if (vec_lo_done)
			pc[7:0] <= i_rdata;
		else if (bus_done && (state == ST_FETCH))
			pc <= pc + 13'h0001;
	end

	// Wider view pads with zeros above the thirteen real bits
	assign o_pc16 = {cprs_pkg::PC_UPPER_ZERO, pc};

	// Fetched byte, valid for one clock
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_fetch_valid <= 1'b0;
			o_fetch_data  <= 8'h00;
		end
		else
		begin
			o_fetch_valid <= bus_done && (state == ST_FETCH);
			if (bus_done && (state == ST_FETCH))
				o_fetch_data <= i_rdata;
		end
	end

	assign o_acc = acc;
	assign o_idx = idx;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_wr_cycle;
		o_bus.wr ##1 o_bus.wr ##1 !o_bus.wr;
	endsequence

	AST_CE_HALF: assert property (ce |=> !ce ##1 ce)
		else $error("processor enable not at half rate");

	AST_WR_ONE_CYCLE: assert property ($rose(o_bus.wr) |-> s_wr_cycle)
		else $error("write does not last one processor cycle");

	AST_VEC_LOAD: assert property (state == ST_VEC_LO
		&& o_bus.addr == cprs_pkg::VEC_LO_ADDR && ce
		|=> o_pc16[7:0] == $past(i_rdata) && state == ST_READY)
		else $error("vector low byte not loaded");

	AST_PC_STEP: assert property (state == ST_FETCH && ce
		|=> o_pc16 == $past(o_pc16) + 16'h0001 && o_fetch_valid)
		else $error("fetch pointer did not advance");

	AST_PC_UPPER: assert property (o_pc16[15:13] == 3'h0
		&& o_ccr[7:5] == 3'h7)
		else $error("fixed bits of pointer or flags wrong");

	AST_PUSH: assert property (take_push |=> o_bus.wr
		&& o_bus.addr == {cprs_pkg::STACK_PAGE, $past(o_sp)}
		&& o_bus.wdata == $past(acc) && o_sp == $past(o_sp)
		##2 o_sp == $past(o_sp, 3) - 8'h01)
		else $error("push order wrong");

	AST_PULL: assert property (take_pull |=> o_bus.rd
		&& o_sp == $past(o_sp) + 8'h01
		&& o_bus.addr == {cprs_pkg::STACK_PAGE, o_sp})
		else $error("pull did not pre-increment");

	AST_RSP: assert property (take_rsp |=> o_sp == cprs_pkg::SP_RESET)
		else $error("stack reinit failed");

	AST_HALF: assert property (take_add |=> o_ccr[cprs_pkg::CC_H]
		== ({1'b0, $past(acc[3:0])} + {1'b0, $past(i_cmd.data[3:0])}
		> 5'h0f))
		else $error("half carry wrong");

	AST_BCD: assert property (take_add && i_cmd.op == cprs_pkg::OP_ADDD
		&& acc[3:0] <= 4'h9 && acc[7:4] <= 4'h9
		&& i_cmd.data[3:0] <= 4'h9 && i_cmd.data[7:4] <= 4'h9
		|=> o_acc[3:0] <= 4'h9 && o_acc[7:4] <= 4'h9)
		else $error("decimal result not valid");

endmodule : cprs_core

// File: cprs_mem_model.sv
// Behavioural model of the shared memory and I/O space on the core bus.
// Assumes one clock; a read answers while rd stands, writes land on edges.
`timescale 1ns/1ns

module cprs_mem_model (
	input  wire logic                i_clk,  // Core clock
	input  wire cprs_pkg::cprs_bus_t i_bus,  // Access from the core
	output logic               [7:0] o_rdata // Read data to the core
);
	logic [7:0] mem [0:8191]; // Whole byte space, one byte a location
	logic [7:0] last = 8'h00; // Last byte handed out

	////////////////////////////////////////////////////////////////////
	// Pattern fill from the low address byte, repeating every 256 locations; vector gives 13'h0a34
	initial
	begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		mem[13'h1ffe] = 8'h0a;
		mem[13'h1fff] = 8'h34;
	end

	// Writes and reads alike address one flat space
	always @(posedge i_clk)
	begin
		if (i_bus.wr)
			mem[i_bus.addr] <= i_bus.wdata;
		if (i_bus.rd)
			last <= mem[i_bus.addr];
	end

	// Released data shows the inverse, so a stale capture is caught
	assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~last;
endmodule : cprs_mem_model

// File: cpu_programmer_register_set_tb_top.sv
// Self-checking bench for the core register set and its memory bus.
// Assumes cprs_core and cprs_mem_model; one 10 MHz clock.
`timescale 1ns/1ns

module cpu_programmer_register_set_tb_top;
	logic                clk = 1'b0;  // 100 ns clock
	logic                rst = 1'b1;  // Sync reset
	cprs_pkg::cprs_cmd_t cmd = '0;    // Command to core
	logic                ready;       // Command taken
	logic          [7:0] rdata;       // Memory data
	cprs_pkg::cprs_bus_t bus;         // Memory access
	logic          [7:0] acc, idx, ccr, sp;
	logic         [15:0] pc16;
	logic                fvalid;
	logic          [7:0] fdata;
	int                  mismatches = 0;
	int                  total_checks = 0;
	int                  busy_cycles;  // Clocks with an access up
	logic          [7:0] fetched;      // Last fetched byte

	always #50 clk = ~clk;

	cprs_core dut_u (.i_clk(clk), .i_rst(rst), .i_cmd(cmd),
		.o_cmd_ready(ready), .i_rdata(rdata), .o_bus(bus), .o_acc(acc),
		.o_idx(idx), .o_pc16(pc16), .o_ccr(ccr), .o_sp(sp),
		.o_fetch_valid(fvalid), .o_fetch_data(fdata));

	cprs_mem_model mem_u (.i_clk(clk), .i_bus(bus), .o_rdata(rdata));

	////////////////////////////////////////////////////////////////////
	// Verdict, the single place the run ends
	task automatic conclude;
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// Value compare, widened to 16 bits
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Wait at falling edges until the core is ready, bounded.
	// The current falling edge is looked at first, so the first
	// clock of a bus access is counted too.
	task automatic wait_ready;
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		while (!done && n < 60)
		begin
			if (bus.rd === 1'b1 || bus.wr === 1'b1)
				busy_cycles++;
			if (fvalid === 1'b1)
				fetched = fdata;
			if (ready === 1'b1)
				done = 1'b1;
			else
			begin
				@(negedge clk);
				n++;
			end
		end
		if (!done)
			mismatches++;
	endtask : wait_ready

	// Hold a command until taken, then run it to completion
	task automatic issue(input cprs_pkg::cprs_op_t op, input logic [7:0] d);
		@(posedge clk);
		cmd <= '{1'b1, op, d};
		@(negedge clk);
		wait_ready();
		@(posedge clk);
		cmd <= '{1'b0, cprs_pkg::OP_NOP, 8'h00};
		busy_cycles = 0;
		@(negedge clk);
		wait_ready();
	endtask : issue

	// Model of a binary or decimal add: {carry, half, sum}
	function automatic logic [9:0] add_ref(input logic [7:0] a, b,
		input logic dec);
		logic [8:0] bin;
		logic [8:0] t;
		logic       h;
		logic       hf;
		bin = {1'b0, a} + {1'b0, b};
		h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
		if (!dec)
			return {bin[8], h, bin[7:0]};
		t = {1'b0, bin[7:0]} + ((h || bin[3:0] > 4'h9) ? 9'h006 : 9'h000);
		hf = bin[8] || t[8] || t[7:4] > 4'h9;
		return {hf, h, t[7:0] + (hf ? 8'h60 : 8'h00)};
	endfunction : add_ref

	////////////////////////////////////////////////////////////////////
	// Reset state after the vector pair is read
	task automatic t_reset;
		busy_cycles = 0;
		wait_ready();
		chk("pc16", 16'h0a34, pc16);
		chk("acc", 16'h0000, {8'h00, acc});
		chk("ccr", 16'h00e8, {8'h00, ccr});
		chk("sp", 16'h00ff, {8'h00, sp});
	endtask : t_reset

	// Register loads; flag byte keeps its top three bits high
	task automatic t_regs;
		issue(cprs_pkg::OP_LDA, 8'h5a);
		chk("acc", 16'h005a, {8'h00, acc});
		issue(cprs_pkg::OP_LDX, 8'ha5);
		chk("idx", 16'h00a5, {8'h00, idx});
		issue(cprs_pkg::OP_LDCC, 8'h00);
		chk("ccr", 16'h00e0, {8'h00, ccr});
		issue(cprs_pkg::OP_LDCC, 8'hff);
		chk("ccr", 16'h00ff, {8'h00, ccr});
		issue(cprs_pkg::OP_NOP, 8'h00);
		chk("acc", 16'h005a, {8'h00, acc});
	endtask : t_regs

	// Two fetches in a row, the first checked as one bus cycle long
	task automatic t_fetch;
		issue(cprs_pkg::OP_FETCH, 8'h00);
		chk("fetch", {8'h00, 8'h34 ^ 8'h5a}, {8'h00, fetched});
		chk("pc16", 16'h0a35, pc16);
		chk("busy", 16'h0002, 16'(busy_cycles));
		issue(cprs_pkg::OP_FETCH, 8'h00);
		chk("fetch", {8'h00, 8'h35 ^ 8'h5a}, {8'h00, fetched});
		chk("pc16", 16'h0a36, pc16);
	endtask : t_fetch

	// Push twice, pull twice in reverse order, push once more, then reinit
	task automatic t_stack;
		issue(cprs_pkg::OP_LDA, 8'ha1);
		issue(cprs_pkg::OP_PUSHA, 8'h00);
		chk("sp", 16'h00fe, {8'h00, sp});
		chk("stk", 16'h00a1, {8'h00, mem_u.mem[13'h00ff]});
		issue(cprs_pkg::OP_LDA, 8'hb2);
		issue(cprs_pkg::OP_PUSHA, 8'h00);
		chk("stk", 16'h00b2, {8'h00, mem_u.mem[13'h00fe]});
		issue(cprs_pkg::OP_LDA, 8'h00);
		issue(cprs_pkg::OP_PULLA, 8'h00);
		chk("acc", 16'h00b2, {8'h00, acc});
		chk("sp", 16'h00fe, {8'h00, sp});
		issue(cprs_pkg::OP_PULLA, 8'h00);
		chk("acc", 16'h00a1, {8'h00, acc});
		issue(cprs_pkg::OP_PUSHA, 8'h00);
		issue(cprs_pkg::OP_RSP, 8'h00);
		chk("sp", 16'h00ff, {8'h00, sp});
	endtask : t_stack

	// Store and load through the index register
	task automatic t_index;
		issue(cprs_pkg::OP_LDX, 8'h40);
		issue(cprs_pkg::OP_LDA, 8'h3c);
		issue(cprs_pkg::OP_STAX, 8'h00);
		chk("mem40", 16'h003c, {8'h00, mem_u.mem[13'h0040]});
		issue(cprs_pkg::OP_LDA, 8'h00);
		issue(cprs_pkg::OP_LDAX, 8'h00);
		chk("acc", 16'h003c, {8'h00, acc});
	endtask : t_index

	// Binary and decimal adds across nibble and byte carries
	task automatic t_add;
		logic [16:0] cases [7];
		logic [9:0]  r;
		cases = '{{1'b1, 8'h09, 8'h01}, {1'b1, 8'h08, 8'h08},
			{1'b1, 8'h45, 8'h55}, {1'b1, 8'h99, 8'h99},
			{1'b1, 8'h27, 8'h35}, {1'b0, 8'h0f, 8'h01}, {1'b0, 8'h80, 8'h80}};
		foreach (cases[i])
		begin
			r = add_ref(cases[i][15:8], cases[i][7:0], cases[i][16]);
			issue(cprs_pkg::OP_LDA, cases[i][15:8]);
			issue(cases[i][16] ? cprs_pkg::OP_ADDD : cprs_pkg::OP_ADD,
				cases[i][7:0]);
			chk("sum", {8'h00, r[7:0]}, {8'h00, acc});
			chk("hnzc", {12'h000, r[8], r[7], r[7:0] == 8'h00, r[9]},
				{12'h000, ccr[4], ccr[2:0]});
			chk("half", {15'h0000, r[8]}, {15'h0000, ccr[4]});
		end
	endtask : t_add

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_regs();
		t_fetch();
		t_stack();
		t_index();
		t_add();
		conclude();
	end

	// Watchdog, far beyond the few dozen commands above
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule : cpu_programmer_register_set_tb_top
